// ===== include/hssr_defines.vh
// Constants for the HDLC status report and statistics block
`ifndef HSSR_DEFINES_VH
`define HSSR_DEFINES_VH
`define HSSR_ST_ADDR_ACK 8'h3c
`define HSSR_ST_STAT_ACK 8'h3d
`define HSSR_ST_ILLEGAL 8'h3f
`define HSSR_ST_IN1_CHG 8'h40
`define HSSR_CNT_SAT 8'hff
`define HSSR_WATCH_A 2'h1
`define HSSR_WATCH_B 2'h2
`define HSSR_AUTO_A 2'h1
`define HSSR_AUTO_B 2'h2
`define HSSR_CAUSE_UNDEF 8'h00
`define HSSR_CAUSE_PARAM 8'h01
`define HSSR_CAUSE_STATE 8'h02
`define HSSR_LINK_IDLE 8'h00
`define HSSR_LINK_STBY 8'h01
`define HSSR_LINK_XMIT 8'h02
`define HSSR_SAMPLE_MS 8
`define HSSR_CLK_KHZ 20000
`define HSSR_SAMPLE_CYC (`HSSR_SAMPLE_MS * `HSSR_CLK_KHZ)
`define HSSR_A_MODE 8'h00
`define HSSR_A_FRAME 8'h04
`define HSSR_A_ADDRCNT 8'h08
`define HSSR_A_ADDRVAL 8'h0c
`define HSSR_A_LIMITS 8'h10
`define HSSR_A_CMD 8'h14
`define HSSR_A_STATUS 8'h18
`define HSSR_A_BASE 8'h1c
`define HSSR_A_WPTR 8'h20
`define HSSR_A_RPTR 8'h24
`endif

// ===== logic/hssr_stat_counter.v
// One saturating statistics counter
`timescale 1ns/1ns
`include "hssr_defines.vh"
module hssr_stat_counter (
   input wire clk_i,
   input wire rstn_i,
   input wire inc_i,
   input wire clr_i,
   output reg [7:0] count_o
);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_o <= 8'h00;
      end else if (clr_i) begin
         // A hit in the read-clear cycle is kept, not lost
         count_o <= inc_i ? 8'h01 : 8'h00;
      end else if (inc_i && count_o != `HSSR_CNT_SAT) begin
         count_o <= count_o + 8'h01;
      end
   end
endmodule // hssr_stat_counter

// ===== logic/hssr_status_report.v
// Status report builder with receive statistics, AXI4-Lite control
`timescale 1ns/1ns
`include "hssr_defines.vh"
module hssr_status_report (
   input wire clk_i,
   input wire rstn_i,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire frame_end_i,
   input wire [7:0] frame_err_i,
   input wire frame_aborted_i,
   input wire [15:0] frame_bits_i,
   input wire [15:0] frame_len_i,
   input wire chained_i,
   input wire rx_line_idle_i,
   input wire rx_flag_seen_i,
   input wire xmit_enabled_i,
   input wire [1:0] link_mode_i,
   input wire gp_in1_i,
   input wire gp_in2_i,
   input wire gp_out1_i,
   input wire gp_out2_i,
   output reg [31:0] mem_addr_o,
   output reg [7:0] mem_data_o,
   output reg mem_we_o,
   output wire busy_o
);
   // Frame error inputs, bit index: 0 overrun,1 short,2 addr,3 long,
   // 4 abort,5 crc,6 fractional,7 buffer full (raw)
   reg rst_s1;
   reg rst_n;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   reg [31:0] mode_reg; // [1:0] auto, [3:2] watch, [4] octet
   reg [31:0] addr_cnt;
   reg [31:0] addr_val;
   reg [31:0] limits; // [15:0] buffer size, [31:16] chained max
   reg [31:0] min_len; // minimum frame bits
   reg [31:0] cmd_reg;
   reg [31:0] tbl_base;
   reg [7:0] tbl_rptr;
   reg [7:0] tbl_wptr;
   reg [7:0] entry [0:15];
   reg [4:0] ent_len;
   reg [4:0] ent_idx;
   reg sending;
   reg in1_last;
   reg watch_prev;
   reg pend_cmd;
   reg pend_in1;
   wire [7:0] cnt [0:10];
   wire tbl_full = (tbl_wptr + 8'h01) == tbl_rptr;
   assign busy_o = sending;

   // Counter increments, one error cause per frame, plus status full and buffer full
   wire [1:0] auto_sel = mode_reg[1:0];
   wire addr_on = auto_sel == `HSSR_AUTO_A || auto_sel == `HSSR_AUTO_B;
   wire short_f = frame_err_i[1] | (frame_aborted_i &&
      frame_bits_i < min_len[15:0]);
   wire long_f = chained_i ? (frame_len_i > limits[31:16]) :
      (frame_len_i > limits[15:0]);
   wire [6:0] cause = {frame_err_i[6] & mode_reg[4],
      frame_err_i[5],
      frame_aborted_i & ~short_f,
      long_f, frame_err_i[2] & addr_on, short_f, frame_err_i[0]};
   wire [6:0] win = cause & ~(cause - 7'h01);
   // Counter order: 0 ovr,1 under,2 idle,3 short,4 addr,5 long,
   // 6 abort,7 crc,8 fractional_frame_counter,9 status full,10 buffer full
   wire [10:0] inc = frame_end_i ? {frame_err_i[7],
      tbl_full, win[6], win[5], win[4], win[3],
      win[2], win[1], 1'b0, 1'b0, win[0]} : 11'h000;
   wire clr_stats;
   genvar g;
   generate
      for (g = 0; g < 11; g = g + 1) begin : g_cnt
         hssr_stat_counter u_cnt (
            .clk_i(clk_i),
            .rstn_i(rst_n),
            .inc_i(inc[g]),
            .clr_i(clr_stats),
            .count_o(cnt[g])
         );
      end
   endgenerate

   // 8 ms sampling of line flags
   reg [23:0] smp_cnt;
   reg idle_s;
   reg sync_s;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         smp_cnt <= 24'h000000;
         idle_s <= 1'b0;
         sync_s <= 1'b0;
      end else if ({8'h00, smp_cnt} == `HSSR_SAMPLE_CYC - 1) begin
         smp_cnt <= 24'h000000;
         idle_s <= rx_line_idle_i & xmit_enabled_i;
         sync_s <= rx_flag_seen_i & xmit_enabled_i;
      end else begin
         smp_cnt <= smp_cnt + 24'h000001;
      end
   end

   // AXI4-Lite slave
   reg aw_hold;
   reg w_hold;
   reg [7:0] aw_a;
   reg [31:0] w_d;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_ok = aw_hold | s_axi_awvalid;
   wire w_ok = w_hold | s_axi_wvalid;
   wire [7:0] wa = aw_hold ? aw_a : s_axi_awaddr;
   wire [31:0] wd = w_hold ? w_d : s_axi_wdata;
   wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
   wire wr_cmd = do_wr && wa == `HSSR_A_CMD;
   integer i;
   reg [7:0] sum;
   always @* begin
      sum = 8'h00;
      for (i = 0; i < 11; i = i + 1) sum = sum | cnt[i];
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_a <= 8'h00;
         w_d <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
         mode_reg <= 32'h00000000;
         addr_cnt <= 32'h00000000;
         addr_val <= 32'h00000000;
         limits <= 32'h00000000;
         min_len <= 32'h00000000;
         cmd_reg <= 32'h00000000;
         tbl_base <= 32'h00000000;
         tbl_rptr <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !do_wr) begin
            aw_hold <= 1'b1;
            aw_a <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !do_wr) begin
            w_hold <= 1'b1;
            w_d <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (wa)
               `HSSR_A_MODE: mode_reg <= wd;
               `HSSR_A_FRAME: min_len <= wd;
               `HSSR_A_ADDRCNT: addr_cnt <= wd;
               `HSSR_A_ADDRVAL: addr_val <= wd;
               `HSSR_A_LIMITS: limits <= wd;
               `HSSR_A_CMD: cmd_reg <= wd;
               `HSSR_A_BASE: tbl_base <= wd;
               `HSSR_A_RPTR: tbl_rptr <= wd[7:0];
               default: s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `HSSR_A_MODE: s_axi_rdata <= mode_reg;
               `HSSR_A_FRAME: s_axi_rdata <= min_len;
               `HSSR_A_ADDRCNT: s_axi_rdata <= addr_cnt;
               `HSSR_A_ADDRVAL: s_axi_rdata <= addr_val;
               `HSSR_A_LIMITS: s_axi_rdata <= limits;
               `HSSR_A_CMD: s_axi_rdata <= cmd_reg;
               `HSSR_A_STATUS: s_axi_rdata <= {22'h0, pend_cmd, sum,
                  sending};
               `HSSR_A_BASE: s_axi_rdata <= tbl_base;
               `HSSR_A_WPTR: s_axi_rdata <= {24'h0, tbl_wptr};
               `HSSR_A_RPTR: s_axi_rdata <= {24'h0, tbl_rptr};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Entry builder: command bits [2:0] 1 addr ack, 2 stats, 3 illegal;
   // [9:8] illegal cause, [23:16] slot, [31:24] command code
   wire [1:0] watch = mode_reg[3:2];
   wire watch_on = watch == `HSSR_WATCH_A || watch == `HSSR_WATCH_B;
   wire in1_chg = watch_on && watch_prev && (gp_in1_i != in1_last);
   // A change seen while an entry is being written is held, not lost
   wire build_in1 = !sending && !tbl_full && (in1_chg || pend_in1);
   wire build_cmd = !sending && !tbl_full && !build_in1 && pend_cmd &&
      !wr_cmd;
   // Clearing in the snapshot cycle keeps a hit of that same cycle
   assign clr_stats = build_cmd && cmd_reg[2:0] == 3'h2;
   integer k;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sending <= 1'b0;
         ent_len <= 5'h00;
         ent_idx <= 5'h00;
         tbl_wptr <= 8'h00;
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h00000000;
         mem_data_o <= 8'h00;
         in1_last <= 1'b0;
         watch_prev <= 1'b0;
         pend_cmd <= 1'b0;
         pend_in1 <= 1'b0;
         for (k = 0; k < 16; k = k + 1) entry[k] <= 8'h00;
      end else begin
         mem_we_o <= 1'b0;
         if (in1_chg) pend_in1 <= 1'b1;
         in1_last <= gp_in1_i;
         watch_prev <= watch_on;
         if (wr_cmd) pend_cmd <= 1'b1;
         if (sending) begin
            mem_we_o <= 1'b1;
            mem_addr_o <= tbl_base + {tbl_wptr, 4'h0} + ent_idx;
            mem_data_o <= entry[ent_idx[3:0]];
            ent_idx <= ent_idx + 5'h01;
            if (ent_idx == ent_len - 5'h01) begin
               sending <= 1'b0;
               tbl_wptr <= tbl_wptr + 8'h01;
            end
         end else if (build_in1) begin
            pend_in1 <= 1'b0;
            entry[0] <= `HSSR_ST_IN1_CHG;
            entry[1] <= {2'h0, sync_s, idle_s, gp_in2_i, gp_in1_i,
               gp_out2_i, gp_out1_i};
            ent_len <= 5'h02;
            ent_idx <= 5'h00;
            sending <= 1'b1;
         end else if (build_cmd) begin
            pend_cmd <= 1'b0;
            ent_idx <= 5'h00;
            sending <= 1'b1;
            for (k = 1; k < 16; k = k + 1) entry[k] <= 8'h00;
            case (cmd_reg[2:0])
               3'h1: begin
                  entry[0] <= `HSSR_ST_ADDR_ACK;
                  entry[2] <= addr_cnt[7:0];
                  entry[3] <= addr_val[7:0];
                  entry[4] <= addr_val[15:8];
                  entry[5] <= addr_val[23:16];
                  entry[6] <= addr_val[31:24];
                  ent_len <= 5'h07;
               end
               3'h2: begin
                  entry[0] <= `HSSR_ST_STAT_ACK;
                  entry[1] <= (sum != 8'h00) ? 8'h01 : 8'h00;
                  for (k = 0; k < 11; k = k + 1) entry[k + 2] <= cnt[k];
                  ent_len <= 5'h0d;
               end
               3'h3: begin
                  entry[0] <= `HSSR_ST_ILLEGAL;
                  case (cmd_reg[9:8])
                     2'h0: entry[1] <= `HSSR_CAUSE_UNDEF;
                     2'h1: entry[1] <= `HSSR_CAUSE_PARAM;
                     default: entry[1] <= `HSSR_CAUSE_STATE;
                  endcase
                  case (link_mode_i)
                     2'h0: entry[2] <= `HSSR_LINK_IDLE;
                     2'h1: entry[2] <= `HSSR_LINK_STBY;
                     default: entry[2] <= `HSSR_LINK_XMIT;
                  endcase
                  entry[3] <= cmd_reg[23:16];
                  entry[4] <= cmd_reg[31:24];
                  ent_len <= 5'h05;
               end
               default: sending <= 1'b0;
            endcase
         end
      end
   end
endmodule // hssr_status_report

// ===== testbench/hssr_host_mem.sv
// Host memory holding the status table written by the block
`timescale 1ns/1ns
module hssr_host_mem (
   input wire clk_i,
   input wire we_i,
   input wire [31:0] addr_i,
   input wire [7:0] data_i
);
   reg [7:0] mem [0:4095];
   integer i;
   // Untouched bytes hold a marker so a missing write cannot pass as zero
   initial begin
      for (i = 0; i < 4096; i = i + 1) mem[i] = 8'ha5;
   end
   always @(posedge clk_i) begin
      if (we_i) mem[addr_i[11:0]] <= data_i;
   end
endmodule // hssr_host_mem

// ===== testbench/hssr_status_report_assertions.sv
// Bus and status-table write checks for the status report block
`timescale 1ns/1ns
`include "hssr_defines.vh"
module hssr_checker (
   input wire clk_i,
   input wire rstn_i,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] mem_addr_o,
   input wire [7:0] mem_data_o,
   input wire mem_we_o,
   input wire busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   AST_WRITE_ANSWER:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
         s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
   AST_READ_ANSWER:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_BVALID_HOLD:
      assert property (s_axi_bvalid && !s_axi_bready |=>
         s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   AST_RVALID_HOLD:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
         $stable(s_axi_rdata)) else $error("rvalid dropped");
   AST_BYTE_STEP:
      assert property (mem_we_o && $past(mem_we_o) |->
         mem_addr_o == $past(mem_addr_o) + 32'h1 || mem_addr_o[3:0] == 4'h0)
      else $error("table bytes out of order");
   AST_FIRST_BYTE:
      assert property ($rose(mem_we_o) |-> mem_data_o inside
         {`HSSR_ST_ADDR_ACK, `HSSR_ST_STAT_ACK, `HSSR_ST_ILLEGAL,
         `HSSR_ST_IN1_CHG}) else $error("entry starts without number");
   // The last byte leaves the cycle after busy drops
   AST_WE_BUSY:
      assert property (mem_we_o |-> $past(busy_o))
      else $error("write while idle");
   AST_ENTRY_BOUND:
      assert property ($rose(busy_o) |-> ##[1:40] !busy_o)
      else $error("entry too long");
   cover property ($rose(mem_we_o) && mem_data_o == `HSSR_ST_STAT_ACK);
   cover property ($rose(mem_we_o) && mem_data_o == `HSSR_ST_IN1_CHG);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // hssr_checker

// ===== testbench/hssr_status_report_test.sv
// Self-checking bench for the status report block
`timescale 1ns/1ns
`include "hssr_defines.vh"
module hssr_status_report_test;
   reg clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg [7:0] aw_a = 8'h0, ar_a = 8'h0, fer = 8'h0;
   reg [31:0] w_d = 32'h0;
   reg aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, fe = 0, fab = 0;
   reg fch = 0, idle = 0, flag = 0, xen = 0, gi1 = 0, gi2 = 0, go1 = 0;
   reg go2 = 0;
   reg [1:0] lmode = 2'h0;
   reg [15:0] fbits = 16'h0, flen = 16'h0;
   wire awr, wr, bv, arr, rv, mwe, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rd, maddr;
   wire [7:0] mdata;
   reg [31:0] rdv;
   reg [1:0] brs, rrs;
   reg [7:0] exp_st [0:10];
   integer failures = 0, total_checks = 0, i;
   always #25 clk_i = ~clk_i;
   hssr_status_report dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(awr),
      .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(r_r), .frame_end_i(fe),
      .frame_err_i(fer), .frame_aborted_i(fab), .frame_bits_i(fbits),
      .frame_len_i(flen), .chained_i(fch), .rx_line_idle_i(idle),
      .rx_flag_seen_i(flag), .xmit_enabled_i(xen), .link_mode_i(lmode),
      .gp_in1_i(gi1), .gp_in2_i(gi2), .gp_out1_i(go1), .gp_out2_i(go2),
      .mem_addr_o(maddr), .mem_data_o(mdata), .mem_we_o(mwe),
      .busy_o(busy));
   hssr_host_mem host_u (.clk_i(clk_i), .we_i(mwe), .addr_i(maddr),
      .data_i(mdata));
   task stop_test;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input string n, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("unexpected %s: expected %h seen %h", n, e, g);
         end
      end
   endtask
   task chk_b(input integer s, input integer b, input [7:0] e);
      chk("table byte", {24'h0, e}, {24'h0, host_u.mem[256 + 16 * s + b]});
   endtask
   // Ready is raised a cycle late so the slave must hold its answer
   task axw(input [7:0] a, input [31:0] d);
      begin
         aw_a <= a;
         w_d <= d;
         aw_v <= 1'b1;
         w_v <= 1'b1;
         do begin
            @(posedge clk_i);
            if (aw_v && awr) aw_v <= 1'b0;
            if (w_v && wr) w_v <= 1'b0;
            if (!aw_v && !w_v && !b_r) b_r <= 1'b1;
         end while (!(bv && b_r));
         brs = bresp;
         b_r <= 1'b0;
      end
   endtask
   task axr(input [7:0] a);
      begin
         ar_a <= a;
         ar_v <= 1'b1;
         do begin
            @(posedge clk_i);
            if (ar_v && arr) ar_v <= 1'b0;
            if (!ar_v && !r_r) r_r <= 1'b1;
         end while (!(rv && r_r));
         rdv = rd;
         rrs = rresp;
         r_r <= 1'b0;
      end
   endtask
   task wait_wp(input [31:0] n);
      integer k;
      begin
         k = 0;
         do begin
            axr(`HSSR_A_WPTR);
            k = k + 1;
         end while (rdv !== n && k < 60);
         chk("write pointer", n, rdv);
      end
   endtask
   task frm(input [7:0] e, input ab, input [15:0] b, input [15:0] l,
      input ch);
      begin
         fer <= e;
         fab <= ab;
         fbits <= b;
         flen <= l;
         fch <= ch;
         fe <= 1'b1;
         @(posedge clk_i);
         fe <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   initial begin
      exp_st = '{8'h1, 8'h0, 8'h0, 8'h2, 8'h1, 8'h2, 8'h1, 8'hff, 8'h1,
         8'h0, 8'h1};
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      axr(`HSSR_A_WPTR);
      chk("write pointer", 0, rdv);
      axr(8'h40);
      chk("unmapped read resp", 2, {30'h0, rrs});
      chk("unmapped read data", 0, rdv);
      axw(8'h40, 32'h0);
      chk("unmapped write resp", 2, {30'h0, brs});
      axw(`HSSR_A_MODE, 32'h11);
      axw(`HSSR_A_FRAME, 32'h20);
      axw(`HSSR_A_ADDRCNT, 32'h2);
      axw(`HSSR_A_ADDRVAL, 32'h44332211);
      axw(`HSSR_A_LIMITS, 32'h00400020);
      axw(`HSSR_A_BASE, 32'h100);
      axw(`HSSR_A_CMD, 32'h1);
      wait_wp(1);
      chk("busy", 0, {31'h0, busy});
      chk_b(0, 0, `HSSR_ST_ADDR_ACK);
      chk_b(0, 2, 8'h2);
      chk_b(0, 3, 8'h11);
      chk_b(0, 6, 8'h44);
      frm(8'h21, 0, 100, 8, 0);
      frm(8'h06, 0, 100, 8, 0);
      frm(8'h04, 0, 100, 8, 0);
      frm(8'h00, 0, 100, 100, 0);
      frm(8'h00, 0, 100, 50, 1);
      frm(8'h00, 0, 100, 70, 1);
      frm(8'h00, 1, 100, 8, 0);
      frm(8'h00, 1, 10, 8, 0);
      frm(8'h40, 0, 100, 8, 0);
      frm(8'h80, 0, 100, 8, 0);
      repeat (260) frm(8'h20, 0, 100, 8, 0);
      // The saturated crc counter alone sets every bit, so the OR field is all ones
      axr(`HSSR_A_STATUS);
      chk("status word", 32'h1fe, rdv);
      axw(`HSSR_A_CMD, 32'h2);
      wait_wp(2);
      chk_b(1, 0, `HSSR_ST_STAT_ACK);
      chk_b(1, 1, 8'h1);
      for (i = 0; i < 11; i = i + 1) chk_b(1, i + 2, exp_st[i]);
      axw(`HSSR_A_CMD, 32'h2);
      wait_wp(3);
      chk_b(2, 1, 8'h0);
      for (i = 0; i < 3; i = i + 1) begin
         lmode <= i[1:0];
         axw(`HSSR_A_CMD, {8'h5a, 8'h07, 6'h0, i[1:0], 8'h03});
         wait_wp(4 + i);
         chk_b(3 + i, 0, `HSSR_ST_ILLEGAL);
         chk_b(3 + i, 1, i[7:0]);
         chk_b(3 + i, 2, i[7:0]);
         chk_b(3 + i, 3, 8'h07);
         chk_b(3 + i, 4, 8'h5a);
      end
      go1 <= 1'b1;
      gi2 <= 1'b1;
      xen <= 1'b1;
      idle <= 1'b1;
      flag <= 1'b1;
      axw(`HSSR_A_MODE, 32'h15);
      gi1 <= 1'b1;
      wait_wp(7);
      chk_b(6, 0, `HSSR_ST_IN1_CHG);
      // No 8 ms sample has been taken yet, so idle and sync still read 0
      chk_b(6, 1, 8'h0d);
      axw(`HSSR_A_MODE, 32'h0);
      gi1 <= 1'b0;
      frm(8'h04, 0, 100, 8, 0);
      frm(8'h40, 0, 100, 8, 0);
      axw(`HSSR_A_CMD, 32'h2);
      wait_wp(8);
      chk_b(7, 0, `HSSR_ST_STAT_ACK);
      chk_b(7, 1, 8'h0);
      stop_test;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      failures = failures + 1;
      stop_test;
   end
endmodule // hssr_status_report_test
bind hssr_status_report hssr_checker chk_u (.clk_i(clk_i),
   .rstn_i(rstn_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
   .mem_we_o(mem_we_o), .busy_o(busy_o));
